//--- rtl/ssw_params.svh
// Purpose: Named constants for the scanner status word encoder.
// Assumes: Included by bare name; definitions only.
// Notes: Addresses are byte addresses of 32-bit words.
`ifndef SSW_PARAMS_SVH
`define SSW_PARAMS_SVH
// ****************************************************************
// Register map
// ****************************************************************
`define SSW_ADDR_CTRL 8'h00
`define SSW_ADDR_INEN 8'h04
`define SSW_ADDR_WORD 8'h08
`define SSW_ADDR_ISTAT 8'h0c
`define SSW_ADDR_IMASK 8'h10
`define SSW_ADDR_COUNT 8'h14
`define SSW_CTRL_RST 4'h8
`define SSW_INEN_RST 8'h00
`define SSW_IMASK_RST 4'h0
// ****************************************************************
// Status word layout
// ****************************************************************
`define SSW_B_SAFE 0
`define SSW_B_WARN 1
`define SSW_B_DIRT 2
`define SSW_B_RREQ 3
`define SSW_B_RBTN 4
`define SSW_B_FAULT 5
`define SSW_B_PRIM 6
`define SSW_B_SEC 7
`define SSW_B_SPRIM 8
`define SSW_B_SSEC 9
`define SSW_B_VVAL 10
`define SSW_IN_LO 12
`define SSW_IN_HI 19
`define SSW_VEL_LO 20
`define SSW_VEL_HI 31
// ****************************************************************
// Control fields and timing
// ****************************************************************
`define SSW_C_MODE_LO 0
`define SSW_C_MODE_HI 1
`define SSW_C_COMPAT 2
`define SSW_C_RUN 3
`define SSW_CLK_PERIOD_NS 5
`define SSW_WORD_PERIOD_NS 1000
`define SSW_WORD_CYCLES (`SSW_WORD_PERIOD_NS / `SSW_CLK_PERIOD_NS)
`endif

//--- rtl/ssw_pkg.sv
// Purpose: Types shared by the status word encoder.
// Assumes: Compiled before all design modules.
// Notes: Mode codes are the control register field values.
package ssw_pkg;
  typedef enum logic [1:0] {
    SSW_MODE_DUAL_FIELD = 2'b00,
    SSW_MODE_DUAL_PROT = 2'b01,
    SSW_MODE_TRIPLE = 2'b10,
    SSW_MODE_RSVD = 2'b11
  } ssw_mode_t;
endpackage

//--- rtl/ssw_tick_div.sv
// Purpose: Divides the clock into a one-cycle word sampling enable.
// Assumes: Single clock domain, synchronous active-low reset copy.
// Notes: Stops and reloads while run is low.
`timescale 1ns/10ps
`default_nettype none
`include "ssw_params.svh"
module ssw_tick_div (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  output logic o_tick
);
  logic [15:0] cnt;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 16'h0000;
    end else if (!i_run || cnt == 16'(`SSW_WORD_CYCLES - 1)) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
  assign o_tick = i_run && (cnt == 16'(`SSW_WORD_CYCLES - 1));
endmodule // ssw_tick_div
`default_nettype wire

//--- rtl/ssw_field_map.sv
// Purpose: Maps field occupancy onto the four field bits per mode.
// Assumes: Inputs are 1 while the named field is unoccupied.
// Notes: The reserved mode reports every field as occupied.
`timescale 1ns/10ps
`default_nettype none
module ssw_field_map (
  input wire ssw_pkg::ssw_mode_t i_mode,
  input wire logic i_prot_free,
  input wire logic i_warn_free,
  input wire logic i_prot2_free,
  input wire logic i_warn2_free,
  input wire logic i_simul_prot_free,
  input wire logic i_simul_warn_free,
  input wire logic i_simul_prot2_free,
  output logic o_primary_field_clear,
  output logic o_secondary_field_clear,
  output logic o_simul_primary_clear,
  output logic o_simul_secondary_clear
);
  import ssw_pkg::*;
  always_comb begin
    o_primary_field_clear = 1'b0;
    o_secondary_field_clear = 1'b0;
    o_simul_primary_clear = 1'b0;
    o_simul_secondary_clear = 1'b0;
    case (i_mode)
      SSW_MODE_DUAL_FIELD: begin
        o_primary_field_clear = i_prot_free;
        o_secondary_field_clear = i_warn_free;
        o_simul_primary_clear = i_simul_prot_free;
        o_simul_secondary_clear = i_simul_warn_free;
      end
      SSW_MODE_DUAL_PROT: begin
        o_primary_field_clear = i_prot_free;
        o_secondary_field_clear = i_prot2_free;
        o_simul_primary_clear = i_simul_prot_free;
        o_simul_secondary_clear = i_simul_prot2_free;
      end
      SSW_MODE_TRIPLE: begin
        o_primary_field_clear = i_prot_free;
        o_secondary_field_clear = i_warn_free;
        // Without meaning here, so held at a fixed 0.
        o_simul_primary_clear = 1'b0;
        o_simul_secondary_clear = i_warn2_free;
      end
      default: begin
        o_primary_field_clear = 1'b0;
      end
    endcase
  end
endmodule // ssw_field_map
`default_nettype wire

//--- rtl/ssw_encoder.sv
// Purpose: Assembles the scanner status word sent to the link partner.
// Assumes: All status inputs are synchronous to i_clk.
// Notes: One word is captured per sampling tick, all bits at once.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "ssw_params.svh"
module ssw_encoder (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_safety_output_on,
  input wire logic i_warn1_free,
  input wire logic i_warn2_free,
  input wire logic i_window_dirty,
  input wire logic i_reset_needed,
  input wire logic i_reset_button,
  input wire logic i_device_error,
  input wire logic i_ctrl_in_a_first,
  input wire logic i_ctrl_in_a_second,
  input wire logic i_ctrl_in_b_first,
  input wire logic i_ctrl_in_b_second,
  input wire logic i_ctrl_in_c_first,
  input wire logic i_ctrl_in_c_second,
  input wire logic i_ctrl_in_d_first,
  input wire logic i_ctrl_in_d_second,
  input wire logic i_prot_sel_free,
  input wire logic i_warn_sel_free,
  input wire logic i_prot2_sel_free,
  input wire logic i_warn2_sel_free,
  input wire logic i_simul_prot_free,
  input wire logic i_simul_warn_free,
  input wire logic i_simul_prot2_free,
  input wire logic i_speed_valid,
  input wire logic [11:0] i_speed,
  output logic [31:0] o_status_word,
  output logic o_word_stb,
  output logic o_irq
);
  import ssw_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [3:0] ctrl;
  logic [7:0] inen;
  logic [3:0] istat;
  logic [3:0] imask;
  logic [15:0] word_count;
  ssw_mode_t mode;
  logic compat;
  logic run;
  logic wr_ctrl;
  logic wr_inen;
  logic wr_istat;
  logic wr_imask;

  assign mode = ssw_mode_t'(ctrl[`SSW_C_MODE_HI:`SSW_C_MODE_LO]);
  assign compat = ctrl[`SSW_C_COMPAT];
  assign run = ctrl[`SSW_C_RUN];
  assign wr_ctrl = i_wr && (i_addr == `SSW_ADDR_CTRL);
  assign wr_inen = i_wr && (i_addr == `SSW_ADDR_INEN);
  assign wr_istat = i_wr && (i_addr == `SSW_ADDR_ISTAT);
  assign wr_imask = i_wr && (i_addr == `SSW_ADDR_IMASK);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `SSW_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= i_wdata[3:0];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      inen <= `SSW_INEN_RST;
    end else if (wr_inen) begin
      inen <= i_wdata[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      imask <= `SSW_IMASK_RST;
    end else if (wr_imask) begin
      imask <= i_wdata[3:0];
    end
  end

  // ****************************************************************
  // Word assembly
  // ****************************************************************
  logic tick;
  logic prim_clr;
  logic sec_clr;
  logic sprim_clr;
  logic ssec_clr;
  logic [7:0] in_pins;
  logic [7:0] in_mirror;
  logic [31:0] next_word;

  ssw_tick_div u_div (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_run(run),
    .o_tick(tick)
  );

  ssw_field_map u_map (
    .i_mode(mode),
    .i_prot_free(i_prot_sel_free),
    .i_warn_free(i_warn_sel_free),
    .i_prot2_free(i_prot2_sel_free),
    .i_warn2_free(i_warn2_sel_free),
    .i_simul_prot_free(i_simul_prot_free),
    .i_simul_warn_free(i_simul_warn_free),
    .i_simul_prot2_free(i_simul_prot2_free),
    .o_primary_field_clear(prim_clr),
    .o_secondary_field_clear(sec_clr),
    .o_simul_primary_clear(sprim_clr),
    .o_simul_secondary_clear(ssec_clr)
  );

  assign in_pins = {i_ctrl_in_d_second, i_ctrl_in_d_first,
                    i_ctrl_in_c_second, i_ctrl_in_c_first,
                    i_ctrl_in_b_second, i_ctrl_in_b_first,
                    i_ctrl_in_a_second, i_ctrl_in_a_first};

  // A disabled input reads 0 so the partner never sees a stray pin.
  for (genvar k = 0; k < 8; k++) begin : g_mirror
    assign in_mirror[k] = inen[k] & in_pins[k];
  end

  always_comb begin
    next_word = 32'h0000_0000;
    next_word[`SSW_B_SAFE] = i_safety_output_on;
    next_word[`SSW_B_WARN] = i_warn1_free & i_warn2_free;
    next_word[`SSW_B_DIRT] = i_window_dirty;
    next_word[`SSW_B_RREQ] = i_reset_needed;
    next_word[`SSW_B_RBTN] = i_reset_button;
    next_word[`SSW_B_FAULT] = i_device_error;
    next_word[`SSW_B_PRIM] = prim_clr;
    next_word[`SSW_B_SEC] = sec_clr;
    next_word[`SSW_B_SPRIM] = sprim_clr;
    next_word[`SSW_B_SSEC] = ssec_clr;
    next_word[`SSW_IN_HI:`SSW_IN_LO] = in_mirror;
    if (!compat) begin
      next_word[`SSW_B_VVAL] = i_speed_valid;
      next_word[`SSW_VEL_HI:`SSW_VEL_LO] = i_speed;
    end
  end

  // All bits are taken on the same edge so no word mixes two states.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_status_word <= 32'h0000_0000;
    end else if (tick) begin
      o_status_word <= next_word;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_word_stb <= 1'b0;
    end else begin
      o_word_stb <= tick;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      word_count <= 16'h0000;
    end else if (tick) begin
      word_count <= word_count + 16'h0001;
    end
  end

  // ****************************************************************
  // Events and interrupt
  // ****************************************************************
  logic prev_safe;
  logic prev_err;
  logic prev_dirt;
  logic prev_vval;
  logic [3:0] events;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_safe <= 1'b0;
      prev_err <= 1'b0;
      prev_dirt <= 1'b0;
      prev_vval <= 1'b0;
    end else begin
      prev_safe <= i_safety_output_on;
      prev_err <= i_device_error;
      prev_dirt <= i_window_dirty;
      prev_vval <= i_speed_valid;
    end
  end

  assign events = {prev_vval & ~i_speed_valid,
                   ~prev_dirt & i_window_dirty,
                   ~prev_err & i_device_error,
                   prev_safe & ~i_safety_output_on};

  // A new event in the clearing cycle survives the write-one clear.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat <= 4'h0;
    end else begin
      istat <= (istat & ~(wr_istat ? i_wdata[3:0] : 4'h0)) | events;
    end
  end

  assign o_irq = |(istat & imask);

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        `SSW_ADDR_CTRL: o_rdata <= {28'h0000000, ctrl};
        `SSW_ADDR_INEN: o_rdata <= {24'h000000, inen};
        `SSW_ADDR_WORD: o_rdata <= o_status_word;
        `SSW_ADDR_ISTAT: o_rdata <= {28'h0000000, istat};
        `SSW_ADDR_IMASK: o_rdata <= {28'h0000000, imask};
        `SSW_ADDR_COUNT: o_rdata <= {16'h0000, word_count};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n);

  chk_safe_bit: assert property (
    tick |=> o_word_stb && o_status_word[`SSW_B_SAFE] == $past(i_safety_output_on))
    else $error("safety output bit wrong");
  chk_warn_both: assert property (
    tick |=> o_status_word[`SSW_B_WARN] == ($past(i_warn1_free) && $past(i_warn2_free)))
    else $error("warning bit wrong");
  chk_dirt_bit: assert property (
    tick && i_window_dirty |=> o_status_word[`SSW_B_DIRT])
    else $error("contamination bit missing");
  chk_reset_bits: assert property (
    tick |=> o_status_word[`SSW_B_RREQ] == $past(i_reset_needed))
    else $error("reset pending bit wrong");
  chk_button_bit: assert property (
    tick |=> o_status_word[`SSW_B_RBTN] == $past(i_reset_button))
    else $error("reset button bit wrong");
  chk_fault_bit: assert property (
    tick |=> o_status_word[`SSW_B_FAULT] == $past(i_device_error))
    else $error("fault bit wrong");
  chk_mirror_mask: assert property (
    tick |=> o_status_word[`SSW_IN_HI:`SSW_IN_LO] == ($past(in_pins) & $past(inen)))
    else $error("input mirror wrong");
  chk_primary_bit: assert property (
    tick && mode != SSW_MODE_RSVD |=> o_status_word[`SSW_B_PRIM] == $past(i_prot_sel_free))
    else $error("primary field bit wrong");
  chk_secondary_dp: assert property (
    tick && mode == SSW_MODE_DUAL_PROT |=> o_status_word[`SSW_B_SEC] == $past(i_prot2_sel_free))
    else $error("second protective field bit wrong");
  chk_simul_dual: assert property (
    tick && mode == SSW_MODE_DUAL_FIELD |=>
      o_status_word[`SSW_B_SPRIM] == $past(i_simul_prot_free))
    else $error("simultaneous primary bit wrong");
  chk_triple_simul: assert property (
    tick && mode == SSW_MODE_TRIPLE |=> !o_status_word[`SSW_B_SPRIM])
    else $error("simultaneous primary not zero in triple mode");
  chk_simul_second: assert property (
    tick && mode == SSW_MODE_TRIPLE |=> o_status_word[`SSW_B_SSEC] == $past(i_warn2_sel_free))
    else $error("simultaneous secondary bit wrong");
  chk_speed_word: assert property (
    tick && !compat |=> o_status_word[`SSW_VEL_HI:`SSW_VEL_LO] == $past(i_speed)
      && o_status_word[`SSW_B_VVAL] == $past(i_speed_valid))
    else $error("velocity fields wrong");
  chk_compat_zero: assert property (
    tick && compat |=> o_status_word[`SSW_VEL_HI:`SSW_VEL_LO] == 12'h000
      && !o_status_word[`SSW_B_VVAL])
    else $error("compatibility word carries velocity");
  chk_word_hold: assert property (
    !tick |=> $stable(o_status_word) && !o_word_stb)
    else $error("word changed between ticks");
  chk_irq_sticky: assert property (
    events[0] |=> istat[0] [*2] or (istat[0] ##1 $past(wr_istat)))
    else $error("event flag lost");
  chk_err_event: assert property (
    !i_device_error ##1 i_device_error |=> istat[1])
    else $error("error event flag not set");
  // Read data must fall back to zero so a stale value is never taken as an answer.
  chk_read_idle: assert property (
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");

  cov_word_sent: cover property (o_word_stb ##1 !o_word_stb);
  cov_compat_word: cover property (tick && compat);
  cov_triple_word: cover property (tick && mode == SSW_MODE_TRIPLE);
  cov_irq_raised: cover property ($rose(o_irq));
endmodule // ssw_encoder
`default_nettype wire

//--- dv/ssw_link_partner.sv
// Purpose: Link partner model that receives the scanner status words.
// Assumes: The word strobe is a one-cycle pulse on the system clock.
// Notes: Only the scanner-to-partner direction is modelled; commands back are out of scope.
`timescale 1ns/10ps
`default_nettype none
module ssw_link_partner (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_triple,
  input wire logic [31:0] i_word,
  input wire logic i_word_stb,
  output logic [31:0] o_word,
  output logic [15:0] o_count
);
  // ****************************************************************
  // Word capture
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_word <= 32'h0;
      o_count <= 16'h0;
    end else if (i_word_stb) begin
      // The whole word is taken at one edge, and the meaningless bit is dropped in triple mode.
      o_word <= i_word & ~{23'h0, i_triple, 8'h0};
      o_count <= o_count + 16'h1;
    end
  end
endmodule // ssw_link_partner
`default_nettype wire

//--- dv/scanner_status_word_encoder_bench.sv
// Purpose: Self-checking bench for the status word encoder.
// Assumes: Design package and header are on the compile and include paths.
// Notes: Expected words are built here from the field mapping, never read back from the design.
`timescale 1ns/10ps
`default_nettype none
`include "ssw_params.svh"
module scanner_status_word_encoder_bench;
  logic i_clk, i_arst_n, i_wr, i_rd, o_word_stb, o_irq, triple;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, o_status_word, pw, rv;
  logic [22:0] st;
  logic [11:0] spd;
  logic [15:0] pcnt;
  int err_count, n_tests;
  // ****************************************************************
  // Design and partner
  // ****************************************************************
  ssw_encoder i_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_safety_output_on(st[0]),
    .i_warn1_free(st[1]), .i_warn2_free(st[2]), .i_window_dirty(st[3]), .i_reset_needed(st[4]),
    .i_reset_button(st[5]), .i_device_error(st[6]), .i_ctrl_in_a_first(st[7]),
    .i_ctrl_in_a_second(st[8]), .i_ctrl_in_b_first(st[9]), .i_ctrl_in_b_second(st[10]),
    .i_ctrl_in_c_first(st[11]), .i_ctrl_in_c_second(st[12]), .i_ctrl_in_d_first(st[13]),
    .i_ctrl_in_d_second(st[14]), .i_prot_sel_free(st[15]), .i_warn_sel_free(st[16]),
    .i_prot2_sel_free(st[17]), .i_warn2_sel_free(st[18]), .i_simul_prot_free(st[19]),
    .i_simul_warn_free(st[20]), .i_simul_prot2_free(st[21]), .i_speed_valid(st[22]),
    .i_speed(spd), .o_status_word(o_status_word), .o_word_stb(o_word_stb), .o_irq(o_irq));
  ssw_link_partner i_partner (.i_clk(i_clk), .i_rst_n(i_arst_n), .i_triple(triple),
    .i_word(o_status_word), .i_word_stb(o_word_stb), .o_word(pw), .o_count(pcnt));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  // Returns the cycles waited; a missing strobe ends the run rather than hanging it.
  task automatic wait_stb(output int n);
    n = 0;
    do begin
      @(posedge i_clk);
      #1 n++;
    end while (o_word_stb !== 1'b1 && n < 260);
    if (n >= 260) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      finish_test();
    end
  endtask
  function automatic logic [31:0] exp_word(input logic [1:0] m, input logic c, input logic [7:0] en,
                                           input logic [22:0] s, input logic [11:0] v);
    logic [3:0] f;
    case (m)
      2'd0: f = {s[20], s[19], s[16], s[15]};
      2'd1: f = {s[21], s[19], s[17], s[15]};
      2'd2: f = {s[18], 1'b0, s[16], s[15]};
      default: f = 4'h0;
    endcase
    exp_word = {c ? 12'h0 : v, s[14:7] & en, 1'b0, ~c & s[22], f, s[6:3], s[1] & s[2], s[0]};
  endfunction
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic reset_case;
    rd(`SSW_ADDR_CTRL);
    check(rv, 32'h8);
    rd(`SSW_ADDR_INEN);
    check(rv, 32'h0);
    rd(`SSW_ADDR_IMASK);
    check(rv, 32'h0);
    wr(8'h40, 32'hffffffff);
    rd(8'h40);
    check(rv, 32'h0);
    rd(`SSW_ADDR_CTRL);
    check(rv, 32'h8);
    $display("reset and register map test done");
  endtask
  // The first strobe already sees the new inputs; the second wait times one whole strobe-to-strobe interval.
  task automatic word_case(input logic [1:0] m, input logic c, input logic [7:0] en,
                           input logic [22:0] s, input logic [11:0] v);
    int n;
    wr(`SSW_ADDR_CTRL, {28'h0, 1'b1, c, m});
    wr(`SSW_ADDR_INEN, {24'h0, en});
    triple <= (m == 2'd2);
    st <= s;
    spd <= v;
    wait_stb(n);
    wait_stb(n);
    check(n, 32'd200);
    @(posedge i_clk);
    #1 check(pw, exp_word(m, c, en, s, v));
    rd(`SSW_ADDR_WORD);
    check(rv, exp_word(m, c, en, s, v));
    rd(`SSW_ADDR_COUNT);
    check(rv, {16'h0, pcnt});
    $display("status word test mode %0d compat %0d done", m, c);
  endtask
  task automatic irq_case;
    int n;
    st <= 23'h1;
    repeat (3) @(posedge i_clk);
    wr(`SSW_ADDR_ISTAT, 32'hf);
    wr(`SSW_ADDR_IMASK, 32'h1);
    st[0] <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1 check({31'h0, o_irq}, 32'h1);
    wr(`SSW_ADDR_ISTAT, 32'h1);
    #1 check({31'h0, o_irq}, 32'h0);
    st[6] <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 check({31'h0, o_irq}, 32'h0);
    rd(`SSW_ADDR_ISTAT);
    check(rv, 32'h2);
    wr(`SSW_ADDR_IMASK, 32'h2);
    #1 check({31'h0, o_irq}, 32'h1);
    wr(`SSW_ADDR_ISTAT, 32'h2);
    #1 check({31'h0, o_irq}, 32'h0);
    wr(`SSW_ADDR_CTRL, 32'h0);
    n = 0;
    repeat (250) begin
      @(posedge i_clk);
      #1 n += int'(o_word_stb === 1'b1);
    end
    check(n, 32'd0);
    $display("interrupt and run control test done");
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    err_count = 0;
    n_tests = 0;
    i_arst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    st = 23'h0;
    spd = 12'h0;
    triple = 1'b0;
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    reset_case();
    word_case(2'd0, 1'b0, 8'hff, 23'h7fffff, 12'h830);
    word_case(2'd1, 1'b0, 8'hff, 23'h000000, 12'h7d0);
    word_case(2'd2, 1'b0, 8'h0f, 23'h2aaaaa, 12'h000);
    word_case(2'd1, 1'b1, 8'hf0, 23'h555555, 12'h123);
    word_case(2'd3, 1'b0, 8'h00, 23'h7fffff, 12'hfff);
    word_case(2'd0, 1'b0, 8'h5a, 23'h1a5c3e, 12'h001);
    irq_case();
    finish_test();
  end
endmodule // scanner_status_word_encoder_bench
`default_nettype wire
